// ===== hw/halt_mode_controller.sv
`timescale 1ns/1ps
module halt_mode_controller
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // CPU core and interrupt controller
    input  wire logic        opcode_valid,
    input  wire logic [7:0]  opcode_byte,
    input  wire logic        wake_irq_pending,
    input  wire logic        timebase_irq,
    input  wire logic [1:0]  isr_priority,
    input  wire logic [1:0]  cpu_mask_level,
    input  wire logic        cc_pop,
    input  wire logic        watchdog_enabled,
    // Wake RC oscillator
    input  wire logic        wake_rc_clock,
    // Clock gating and control outputs
    output logic             main_osc_en,
    output logic             cpu_clk_en,
    output logic             periph_clk_en,
    output logic             timebase_clk_en,
    output logic             wake_rc_en,
    output logic             timer_capture_input_two,
    output logic             cc_push,
    output logic             cc_mask_force,
    output logic [1:0]       cc_mask_value,
    output logic             cpu_vector_go,
    output logic             vector_is_reset,
    output logic             watchdog_reset_req,
    output logic             auto_wake_irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        halt_mode_pkg::power_state_t state;
        logic [12:0] stab_cnt;
        logic [12:0] stab_age;
        logic [5:0]  div_cnt;
        logic [7:0]  pre_cnt;
        logic [7:0]  rcs_cnt;
        logic        rc_meta;
        logic        rc_sync;
        logic        rc_prev;
        logic        wake_reset;
        logic [1:0]  saved_mask;
        logic        auto_wake_enable;
        logic        auto_wake_measure;
        logic        auto_wake_flag;
        logic [7:0]  auto_wake_prescaler;
        logic        timebase_irq_enable;
        logic        watchdog_halt_option;
        logic        long_startup;
        logic        ack;
        logic [31:0] rdata;
        logic        osc_en;
        logic        cpu_en;
        logic        per_en;
        logic        tb_en;
        logic        rc_en;
        logic        cap_two;
        logic        push;
        logic        mforce;
        logic [1:0]  mval;
        logic        vgo;
        logic        vreset;
        logic        wdg_req;
    } ctl_t;

    ctl_t state_ff;
    ctl_t nxt_state;

    logic        bus_req;
    logic        bus_wr;
    logic        bus_rd;
    logic [7:0]  bus_idx;
    logic        halt_decoded;
    logic        rc_rise;
    logic [12:0] stab_last;

    assign bus_req      = wb_cyc_i && wb_stb_i && !state_ff.ack;
    assign bus_wr       = bus_req && wb_we_i && wb_sel_i[0];
    assign bus_rd       = bus_req && !wb_we_i;
    assign bus_idx      = {2'h0, wb_adr_i[7:2]};
    assign halt_decoded = opcode_valid && (opcode_byte == halt_mode_pkg::OPC_HALT); // RULE21
    assign rc_rise      = state_ff.rc_sync && !state_ff.rc_prev;
    assign stab_last    = state_ff.long_startup ? (halt_mode_pkg::STARTUP_LONG_CYCLES - 13'h1)
                        : {1'b0, halt_mode_pkg::STARTUP_SHORT_CYCLES - 12'h1};

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        nxt_state         = state_ff;
        nxt_state.rc_meta = wake_rc_clock;
        nxt_state.rc_sync = state_ff.rc_meta;
        nxt_state.rc_prev = state_ff.rc_sync;
        nxt_state.push    = 1'b0;
        nxt_state.mforce  = 1'b0;
        nxt_state.vgo     = 1'b0;
        nxt_state.wdg_req = 1'b0;
        nxt_state.ack     = bus_req;

        // Register writes
        if (bus_wr)
        begin
            case (bus_idx)
                halt_mode_pkg::IDX_AUTO_WAKE_CTRL_STATUS:
                begin
                    nxt_state.auto_wake_enable  = wb_dat_i[halt_mode_pkg::AWCS_ENABLE_BIT];
                    nxt_state.auto_wake_measure = wb_dat_i[halt_mode_pkg::AWCS_MEASURE_BIT];
                end
                halt_mode_pkg::IDX_AUTO_WAKE_PRESCALER:
                begin
                    if (wb_dat_i[7:0] != 8'h00) // RULE24
                    begin
                        nxt_state.auto_wake_prescaler = wb_dat_i[7:0];
                    end
                end
                halt_mode_pkg::IDX_HALT_CONFIG:
                begin
                    nxt_state.timebase_irq_enable =
                        wb_dat_i[halt_mode_pkg::CFG_TIMEBASE_IRQ_EN_BIT];
                    nxt_state.watchdog_halt_option =
                        wb_dat_i[halt_mode_pkg::CFG_WDG_HALT_OPTION_BIT];
                    nxt_state.long_startup = wb_dat_i[halt_mode_pkg::CFG_LONG_STARTUP_BIT];
                end
                default:
                begin
                end
            endcase
        end

        // Register reads; unmapped reads return zero
        nxt_state.rdata = 32'h0000_0000;
        if (bus_rd)
        begin
            case (bus_idx)
                halt_mode_pkg::IDX_AUTO_WAKE_CTRL_STATUS:
                begin
                    nxt_state.rdata[halt_mode_pkg::AWCS_ENABLE_BIT]  = state_ff.auto_wake_enable;
                    nxt_state.rdata[halt_mode_pkg::AWCS_MEASURE_BIT] = state_ff.auto_wake_measure;
                    nxt_state.rdata[halt_mode_pkg::AWCS_FLAG_BIT]    = state_ff.auto_wake_flag;
                    nxt_state.auto_wake_flag = 1'b0; // RULE15
                end
                halt_mode_pkg::IDX_AUTO_WAKE_PRESCALER:
                begin
                    nxt_state.rdata[7:0] = state_ff.auto_wake_prescaler;
                end
                halt_mode_pkg::IDX_HALT_CONFIG:
                begin
                    nxt_state.rdata[halt_mode_pkg::CFG_TIMEBASE_IRQ_EN_BIT] =
                        state_ff.timebase_irq_enable;
                    nxt_state.rdata[halt_mode_pkg::CFG_WDG_HALT_OPTION_BIT] =
                        state_ff.watchdog_halt_option;
                    nxt_state.rdata[halt_mode_pkg::CFG_LONG_STARTUP_BIT] = state_ff.long_startup;
                end
                halt_mode_pkg::IDX_HALT_STATUS:
                begin
                    nxt_state.rdata[4:0] = state_ff.state;
                end
                default:
                begin
                end
            endcase
        end

        // Mask restore when the condition codes come back off the stack
        if (cc_pop)
        begin
            nxt_state.mforce = 1'b1; // RULE20
            nxt_state.mval   = state_ff.saved_mask;
        end

        case (state_ff.state)
            halt_mode_pkg::ST_RUN:
            begin
                if (halt_decoded)
                begin
                    nxt_state.saved_mask = cpu_mask_level;
                    nxt_state.mforce     = 1'b1;
                    if (state_ff.timebase_irq_enable)
                    begin
                        nxt_state.state = halt_mode_pkg::ST_ACTIVE; // RULE6 RULE11
                        nxt_state.mval  = halt_mode_pkg::MASK_ACT_ENTRY; // RULE9
                    end
                    else if (watchdog_enabled && !state_ff.watchdog_halt_option)
                    begin
                        nxt_state.wdg_req = 1'b1; // RULE5 RULE19
                        nxt_state.mforce  = 1'b0;
                    end
                    else
                    begin
                        nxt_state.mval = halt_mode_pkg::MASK_HALT_ENTRY; // RULE3 RULE17
                        nxt_state.div_cnt = 6'h00;
                        nxt_state.pre_cnt = 8'h00;
                        nxt_state.rcs_cnt = 8'h00;
                        if (state_ff.auto_wake_enable)
                        begin
                            nxt_state.state = halt_mode_pkg::ST_AWU; // RULE12
                        end
                        else
                        begin
                            nxt_state.state = halt_mode_pkg::ST_HALT; // RULE1
                        end
                    end
                end
            end
            halt_mode_pkg::ST_HALT:
            begin
                if (wake_irq_pending)
                begin
                    nxt_state.state    = halt_mode_pkg::ST_STARTUP; // RULE2 RULE3
                    nxt_state.stab_cnt = 13'h0000;
                end
            end
            halt_mode_pkg::ST_ACTIVE:
            begin
                if (wake_irq_pending || timebase_irq)
                begin
                    nxt_state.state  = halt_mode_pkg::ST_RUN; // RULE7 RULE8
                    nxt_state.vgo    = 1'b1;
                    nxt_state.vreset = 1'b0;
                    nxt_state.push   = 1'b1;
                    nxt_state.mforce = 1'b1;
                    nxt_state.mval   = isr_priority;
                end
            end
            halt_mode_pkg::ST_AWU:
            begin
                if (rc_rise) // RULE13 RULE23
                begin
                    if (state_ff.rcs_cnt != halt_mode_pkg::RC_START_PERIODS)
                    begin
                        nxt_state.rcs_cnt = state_ff.rcs_cnt + 8'h01;
                    end
                    else if (state_ff.div_cnt != halt_mode_pkg::WAKE_FIXED_DIV_LAST)
                    begin
                        nxt_state.div_cnt = state_ff.div_cnt + 6'h01;
                    end
                    else
                    begin
                        nxt_state.div_cnt = 6'h00;
                        nxt_state.pre_cnt = state_ff.pre_cnt + 8'h01;
                    end
                end
                if (state_ff.pre_cnt == state_ff.auto_wake_prescaler)
                begin
                    nxt_state.auto_wake_flag = 1'b1; // RULE14
                    nxt_state.state          = halt_mode_pkg::ST_STARTUP;
                    nxt_state.stab_cnt       = 13'h0000;
                end
                else if (wake_irq_pending)
                begin
                    nxt_state.state    = halt_mode_pkg::ST_STARTUP;
                    nxt_state.stab_cnt = 13'h0000;
                end
            end
            halt_mode_pkg::ST_STARTUP:
            begin
                if (state_ff.stab_cnt == stab_last) // RULE26
                begin
                    nxt_state.state  = halt_mode_pkg::ST_RUN;
                    nxt_state.vgo    = 1'b1;
                    nxt_state.vreset = state_ff.wake_reset;
                    nxt_state.wake_reset = 1'b0;
                    if (!state_ff.wake_reset)
                    begin
                        nxt_state.push   = 1'b1; // RULE20
                        nxt_state.mforce = 1'b1;
                        nxt_state.mval   = isr_priority;
                    end
                end
                else
                begin
                    nxt_state.stab_cnt = state_ff.stab_cnt + 13'h0001; // RULE2
                end
            end
            default:
            begin
                nxt_state.state = halt_mode_pkg::ST_RUN;
            end
        endcase

        // Clock gating follows the coming state
        nxt_state.osc_en = !(nxt_state.state inside {halt_mode_pkg::ST_HALT,
                                                     halt_mode_pkg::ST_AWU}); // RULE4 RULE18
        nxt_state.cpu_en = (nxt_state.state == halt_mode_pkg::ST_RUN); // RULE26
        nxt_state.per_en = (nxt_state.state == halt_mode_pkg::ST_RUN); // RULE10
        nxt_state.tb_en  = (nxt_state.state inside {halt_mode_pkg::ST_RUN,
                                                    halt_mode_pkg::ST_ACTIVE});
        nxt_state.rc_en  = (nxt_state.state == halt_mode_pkg::ST_AWU)
                        || ((nxt_state.state == halt_mode_pkg::ST_RUN)
                            && nxt_state.auto_wake_measure);
        nxt_state.cap_two = (state_ff.state == halt_mode_pkg::ST_RUN)
                         && state_ff.auto_wake_measure && state_ff.rc_sync; // RULE16
        // Cycles spent in start-up, watched by the start-up age check
        nxt_state.stab_age = (state_ff.state == halt_mode_pkg::ST_STARTUP)
                           ? state_ff.stab_age + 13'h0001 : 13'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff                      <= '0;
            state_ff.state                <= halt_mode_pkg::ST_STARTUP;
            state_ff.wake_reset           <= 1'b1;
            state_ff.auto_wake_prescaler  <= halt_mode_pkg::RST_AUTO_WAKE_PRESCALER; // RULE25
            state_ff.timebase_irq_enable  <= halt_mode_pkg::RST_HALT_CONFIG[0];
            state_ff.watchdog_halt_option <= halt_mode_pkg::RST_HALT_CONFIG[1];
            state_ff.long_startup         <= halt_mode_pkg::RST_HALT_CONFIG[2];
            state_ff.osc_en               <= 1'b1;
            state_ff.tb_en                <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign wb_dat_o                = state_ff.rdata;
    assign wb_ack_o                = state_ff.ack;
    assign main_osc_en             = state_ff.osc_en;
    assign cpu_clk_en              = state_ff.cpu_en;
    assign periph_clk_en           = state_ff.per_en;
    assign timebase_clk_en         = state_ff.tb_en;
    assign wake_rc_en              = state_ff.rc_en;
    assign timer_capture_input_two = state_ff.cap_two;
    assign cc_push                 = state_ff.push;
    assign cc_mask_force           = state_ff.mforce;
    assign cc_mask_value           = state_ff.mval;
    assign cpu_vector_go           = state_ff.vgo;
    assign vector_is_reset         = state_ff.vreset;
    assign watchdog_reset_req      = state_ff.wdg_req;
    assign auto_wake_irq           = state_ff.auto_wake_flag;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_PLAIN_HALT_ENTRY: assert property ( // RULE1
        (state_ff.state == halt_mode_pkg::ST_RUN) && halt_decoded
        && !state_ff.timebase_irq_enable && !state_ff.auto_wake_enable
        && !(watchdog_enabled && !state_ff.watchdog_halt_option)
        |=> (state_ff.state == halt_mode_pkg::ST_HALT) && cc_mask_force
            && (cc_mask_value == 2'h2) && !main_osc_en)
        else $error("plain halt not entered");

    AST_ACTIVE_ENTRY: assert property ( // RULE6
        (state_ff.state == halt_mode_pkg::ST_RUN) && halt_decoded && state_ff.timebase_irq_enable
        |=> (state_ff.state == halt_mode_pkg::ST_ACTIVE) && !watchdog_reset_req
            && (cc_mask_value == 2'h0) && main_osc_en && timebase_clk_en && !periph_clk_en)
        else $error("active halt not entered");

    AST_AWU_ENTRY: assert property ( // RULE12
        (state_ff.state == halt_mode_pkg::ST_RUN) && halt_decoded
        && !state_ff.timebase_irq_enable && state_ff.auto_wake_enable
        && !(watchdog_enabled && !state_ff.watchdog_halt_option)
        |=> (state_ff.state == halt_mode_pkg::ST_AWU) && wake_rc_en && !main_osc_en)
        else $error("auto wake halt not entered");

    AST_WDG_RESET: assert property ( // RULE5
        (state_ff.state == halt_mode_pkg::ST_RUN) && halt_decoded && watchdog_enabled
        && !state_ff.watchdog_halt_option && !state_ff.timebase_irq_enable
        |=> watchdog_reset_req && (state_ff.state == halt_mode_pkg::ST_RUN))
        else $error("watchdog reset missing");

    AST_HALT_WAKE: assert property ( // RULE2
        (state_ff.state == halt_mode_pkg::ST_HALT) && wake_irq_pending
        |=> main_osc_en && !cpu_clk_en ##1 !cpu_clk_en[*8])
        else $error("halt wake did not start oscillator");

    AST_STARTUP_LENGTH: assert property ( // RULE26
        $rose(state_ff.state == halt_mode_pkg::ST_STARTUP) && !state_ff.long_startup
        |-> ##256 (cpu_vector_go && cpu_clk_en))
        else $error("short start-up delay wrong");

    AST_STARTUP_AGE: assert property ( // RULE2
        cpu_vector_go && (state_ff.stab_age != 13'h0000)
        |-> state_ff.stab_age == (state_ff.long_startup ? halt_mode_pkg::STARTUP_LONG_CYCLES
            : {1'b0, halt_mode_pkg::STARTUP_SHORT_CYCLES}))
        else $error("start-up delay length wrong");

    AST_ACTIVE_NO_DELAY: assert property ( // RULE8
        (state_ff.state == halt_mode_pkg::ST_ACTIVE) && timebase_irq
        |=> cpu_vector_go && !vector_is_reset && cc_push && cpu_clk_en)
        else $error("active halt interrupt exit delayed");

    AST_FLAG_CLEAR: assert property ( // RULE15
        bus_rd && (bus_idx == halt_mode_pkg::IDX_AUTO_WAKE_CTRL_STATUS)
        && (state_ff.state != halt_mode_pkg::ST_AWU)
        |=> !auto_wake_irq && wb_ack_o)
        else $error("flag not cleared by read");

    AST_PRESCALER_ZERO: assert property ( // RULE24
        bus_wr && (bus_idx == halt_mode_pkg::IDX_AUTO_WAKE_PRESCALER) && (wb_dat_i[7:0] == 8'h00)
        |=> $stable(state_ff.auto_wake_prescaler))
        else $error("prescaler took zero");

    AST_AWU_EXPIRY: assert property ( // RULE14
        (state_ff.state == halt_mode_pkg::ST_AWU)
        && (state_ff.pre_cnt == state_ff.auto_wake_prescaler)
        |=> auto_wake_irq && main_osc_en && (state_ff.state == halt_mode_pkg::ST_STARTUP))
        else $error("auto wake expiry missed");

endmodule

// ===== hw/halt_mode_pkg.sv
// Notes on behaviour
// RULE1 - Halt instruction with timebase and auto-wake enables clear enters plain Halt.
// RULE2 - Halt left by wake interrupt or reset: oscillator on, 256/4096 cycle delay, resume.
// RULE3 - Entering Halt forces mask bits to 10b; a pending interrupt wakes at once.
// RULE4 - In Halt the main oscillator, CPU and peripherals are stopped.
// RULE5 - Watchdog-halt option decides if halt with watchdog on gives watchdog reset.
// RULE6 - Halt instruction with timebase enable set, auto-wake clear enters Active-halt.
// RULE7 - Active-halt is left on timebase interrupt, other wake interrupts, or reset.
// RULE8 - Start-up delay after Active-halt only on reset exit, never on interrupt exit.
// RULE9 - Entering Active-halt clears mask bits; a pending interrupt wakes at once.
// RULE10 - In Active-halt only main oscillator and timebase counter keep running.
// RULE11 - Active-halt never produces a watchdog reset on the halt instruction.
// RULE12 - Halt instruction with auto-wake set, timebase clear enters auto-wakeup Halt.
// RULE13 - Auto-wakeup Halt runs wake RC clock through fixed divider and prescaler.
// RULE14 - On expiry: set flag and interrupt, start oscillator, delay, then service it.
// RULE15 - Reading the auto-wake control/status register clears flag and its interrupt.
// RULE16 - Measurement bit in Run routes wake RC clock to timer capture input two.
// RULE17 - Entering auto-wakeup Halt forces mask bits to 10b; pending interrupt wakes.
// RULE18 - Auto-wakeup Halt stops main oscillator and peripherals, wake RC excepted.
// RULE19 - Auto-wakeup Halt follows the watchdog-halt option like plain Halt.
// RULE20 - Before wake service push condition codes, set mask to priority; pop restores.
// RULE21 - Opcode byte 8Eh is decoded as the halt instruction.
// RULE22 - Software ensures a wake source, configures wake pins, may clear pending bits.
// RULE23 - Auto-wake halt lasts 64 times prescaler wake RC periods plus RC start-up.
// RULE24 - Prescaler value 00h is forbidden; a write of 00h leaves it unchanged.
// RULE25 - Prescaler resets to FFh; values 01h to FFh divide by their own value.
// RULE26 - CPU clock stays gated until the stabilisation count ends, then vectors.
package halt_mode_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_AUTO_WAKE_CTRL_STATUS = 8'h2E;
    localparam logic [7:0] IDX_AUTO_WAKE_PRESCALER   = 8'h2F;
    localparam logic [7:0] IDX_HALT_CONFIG           = 8'h30;
    localparam logic [7:0] IDX_HALT_STATUS           = 8'h31;

    // Auto-wake control/status fields
    localparam int AWCS_ENABLE_BIT  = 0;
    localparam int AWCS_MEASURE_BIT = 1;
    localparam int AWCS_FLAG_BIT    = 2;

    // Halt configuration fields
    localparam int CFG_TIMEBASE_IRQ_EN_BIT = 0;
    localparam int CFG_WDG_HALT_OPTION_BIT = 1;
    localparam int CFG_LONG_STARTUP_BIT    = 2;

    // Reset values
    localparam logic [7:0] RST_AUTO_WAKE_PRESCALER = 8'hFF;
    localparam logic [2:0] RST_HALT_CONFIG         = 3'h4;

    // Opcodes and mask levels
    localparam logic [7:0] OPC_HALT        = 8'h8E;
    localparam logic [1:0] MASK_HALT_ENTRY = 2'h2;
    localparam logic [1:0] MASK_ACT_ENTRY  = 2'h0;

    // Timing counts, in CPU cycles or wake RC periods
    localparam logic [11:0] STARTUP_SHORT_CYCLES = 12'h100;
    localparam logic [12:0] STARTUP_LONG_CYCLES  = 13'h1000;
    localparam logic [5:0]  WAKE_FIXED_DIV_LAST  = 6'h3F;
    localparam logic [7:0]  RC_START_PERIODS     = 8'h02;

    ////////////////////////////////////////////////////////////////////////////////
    // Power state, one-hot
    typedef enum logic [4:0] {
        ST_RUN     = 5'h01,
        ST_HALT    = 5'h02,
        ST_ACTIVE  = 5'h04,
        ST_AWU     = 5'h08,
        ST_STARTUP = 5'h10
    } power_state_t;

endpackage

// ===== verification/cpu_partner.sv
`timescale 1ns/1ps
module cpu_partner
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Controller side
    input  wire logic       cc_push,
    input  wire logic       cc_mask_force,
    input  wire logic [1:0] cc_mask_value,
    output logic      [1:0] cpu_mask_level,
    output logic            cc_pop
);
    logic [3:0] ret_ff;
    // Mask follows every forced value; the service routine returns four cycles after entry
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            cpu_mask_level <= 2'h3;
            ret_ff         <= 4'h0;
        end
        else
        begin
            if (cc_mask_force)
                cpu_mask_level <= cc_mask_value;
            ret_ff <= {ret_ff[2:0], cc_push};
        end
    assign cc_pop = ret_ff[3];
endmodule

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
    logic        clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00, opcode_byte = 8'h00;
    logic [3:0]  wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, seed = 32'h0EE7;
    logic        opcode_valid = 1'b0, wake_irq_pending = 1'b0, timebase_irq = 1'b0;
    logic        watchdog_enabled = 1'b0, wake_rc_clock, cc_pop, wb_ack_o, cc_push;
    logic [1:0]  isr_priority = 2'h0, cpu_mask_level, cc_mask_value, rc_ff = 2'h0;
    logic        main_osc_en, cpu_clk_en, periph_clk_en, timebase_clk_en, wake_rc_en;
    logic        timer_capture_input_two, cc_mask_force, cpu_vector_go, vector_is_reset;
    logic        watchdog_reset_req, auto_wake_irq, prev;
    int          n_fail = 0, check_count = 0, n, t;
    always #4 clk = ~clk;
    // Wake RC clock stands still unless enabled
    always @(posedge clk) if (wake_rc_en) rc_ff <= rc_ff + 2'h1;
    assign wake_rc_clock = rc_ff[1];
    halt_mode_controller halt_mode_controller_inst (.*);
    cpu_partner cpu_partner_inst (.*);
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic close_out;
        if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] a);
        check_count++;
        if (a !== e)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, e, a);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int i;
        i = 0;
        @(posedge clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, 24'h0, d};
        // Request stands until ack is seen at a rising edge; data is taken there
        do
        begin
            @(posedge clk);
            i++;
        end
        while (wb_ack_o !== 1'b1 && i < 50);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        if (i >= 50)
        begin
            n_fail++;
            close_out();
        end
    endtask
    task automatic issue(input logic [7:0] op);
        @(posedge clk);
        {opcode_valid, opcode_byte} <= {1'b1, op};
        @(posedge clk);
        opcode_valid <= 1'b0;
        @(negedge clk);
    endtask
    // Counts negedges until the vector release or the auto-wake interrupt appears
    task automatic wait_hi(input logic sel);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while ((sel ? auto_wake_irq : cpu_vector_go) !== 1'b1 && n < 6000);
        if (n >= 6000)
        begin
            n_fail++;
            close_out();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        wait_hi(0);
        chk("reset_delay", 1, n >= 4096 && n <= 4099);
        chk("reset_vector", 2'h3, {vector_is_reset, cpu_clk_en});
        bus(0, 8'hBC, 0);
        chk("prescaler_reset", 32'hFF, q);
        bus(1, 8'hBC, 8'h00);
        bus(0, 8'hBC, 0);
        chk("prescaler_zero", 32'hFF, q);
        bus(0, 8'hF8, 0);
        chk("unmapped", 0, q);
        repeat (8)
        begin
            seed = xs(seed);
            issue(seed[7:0] ^ {7'h0, seed[7:0] == 8'h8E});
            chk("non_halt_opcode", 2'h3, {main_osc_en, cpu_clk_en});
        end
        bus(1, 8'hC0, 8'h02);
        watchdog_enabled <= 1'b1;
        issue(8'h8E);
        chk("halt_mask", 3'h6, {cc_mask_force, cc_mask_value});
        chk("halt_gates", 0, {main_osc_en, cpu_clk_en, periph_clk_en});
        @(posedge clk);
        isr_priority <= seed[9:8];
        wake_irq_pending <= 1'b1;
        wait_hi(0);
        chk("halt_delay", 1, n >= 256 && n <= 260);
        chk("halt_push", {1'b1, isr_priority, 1'b0},
            {cc_push, cc_mask_value, vector_is_reset});
        @(posedge clk);
        wake_irq_pending <= 1'b0;
        bus(1, 8'hC0, 8'h01);
        issue(8'h8E);
        chk("active_wdg", 0, watchdog_reset_req);
        chk("active_mask", 0, cc_mask_value);
        chk("active_gates", 4'hC,
            {main_osc_en, timebase_clk_en, periph_clk_en, cpu_clk_en});
        @(posedge clk);
        timebase_irq <= 1'b1;
        wait_hi(0);
        chk("active_wake", 1, n <= 3);
        @(posedge clk);
        timebase_irq <= 1'b0;
        bus(1, 8'hB8, 8'h02);
        t = 0;
        repeat (60)
        begin
            prev = timer_capture_input_two;
            @(negedge clk);
            t += (prev !== timer_capture_input_two);
        end
        chk("capture_route", 1, t > 4);
        bus(1, 8'hB8, 8'h01);
        bus(1, 8'hBC, 8'h01);
        bus(1, 8'hC0, 8'h02);
        issue(8'h8E);
        chk("awu_mask", 2'h2, cc_mask_value);
        chk("awu_gates", 2'h1, {main_osc_en, wake_rc_en});
        wait_hi(1);
        chk("awu_time", 1, n >= 264 && n <= 290);
        wait_hi(0);
        chk("awu_delay", 1, n >= 255 && n <= 260);
        bus(0, 8'hB8, 0);
        chk("awu_flag", 32'h05, q);
        bus(0, 8'hB8, 0);
        chk("awu_clear", 32'h01, q);
        chk("awu_irq_clear", 0, auto_wake_irq);
        bus(1, 8'hC0, 8'h00);
        issue(8'h8E);
        chk("wdg_reset", 1, watchdog_reset_req);
        close_out();
    end
endmodule
